// [inc/charge_seq_defs.svh]
/*
  Constants for the charge cycle sequencer: codes, defaults and timing counts.
  Assumes a 200 MHz core clock; voltages in mV, currents in mA.
*/
`ifndef CHARGE_SEQ_DEFS_SVH
`define CHARGE_SEQ_DEFS_SVH

`define CLK_MHZ 200
`define PH_IDLE 3'h0
`define PH_TRICKLE 3'h1
`define PH_PRE 3'h2
`define PH_CC 3'h3
`define PH_CV 3'h4
`define PH_TOPOFF 3'h6
`define PH_DONE 3'h7
`define SHORT_EXIT_MV 16'h08ca
`define SHORTZ_REG_MV_CELL 16'h09c4
`define TRICKLE_MA 16'h0064
`define PRECHG_DEF_MA 16'h0078
`define TERM_DEF_MA 16'h00c8
`define LDO_CAP_MA 16'h07d0
`define FAST_DEF_LO_MA 16'h07d0
`define FAST_DEF_HI_MA 16'h03e8
`define BATTERY_REGULATION_VOLTAGE_1S_MV 16'h1068
`define BATTERY_REGULATION_VOLTAGE_STEP_MV 16'h1068
`define RECHG_STEP_MV 16'h0064
`define LOWV_RATIO_NUM 16'h0047
`define LOWV_RATIO_DEN 16'h0064
`define IDEAL_DIODE_MV 16'h0019
`define FAST_TMR_DEF_H 8'h0c
`define PRE_TMR_DEF_H 8'h02
`define TRICKLE_TMR_H 8'h01
`define DEGLITCH_US 32'd1024
`define DEGLITCH_CYC (`DEGLITCH_US * `CLK_MHZ)
`define SHORTZ_US 32'd30000
`define SHORTZ_CYC (`SHORTZ_US * `CLK_MHZ)
`define BLINK_HALF_CYC 32'd100000000
`define HOUR_CYC 64'd720000000000
`define ALERT_CYC 8'h20

`endif

// [inc/charge_seq_pkg.sv]
/*
  Types for the charge cycle sequencer.
  Assumes charge_seq_defs.svh is compiled alongside.
*/
package charge_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRICKLE,
    ST_SHORTZ,
    ST_PRE,
    ST_CC,
    ST_CV,
    ST_DONE,
    ST_FAULT
  } seq_state_t;
endpackage

// [rtl/charge_cycle_sequencer.sv]
/*
  Charge cycle sequencer: start, phase selection, termination, recharge and status.
  Assumes analog comparisons and battery/rail voltages are delivered as digitised levels
  from other clock domains; each is synchronised here before use.
*/
// Contract
// - Enabled charging runs whole cycle autonomously.
// - Live parameter inputs govern ongoing charge.
// - Start needs input, enable, and deglitched low battery or enable edge.
// - Terminate on low current, high voltage, unregulated.
// - Recharge below two-bit selectable threshold.
// - Enable pin or bit toggle restarts cycle.
// - Status low charging, high done, blink fault.
// - Status disable bit stops driving status.
// - Phase code values per charging phase.
// - Each phase code change pulses alert.
// - Start phase chosen from battery voltage.
// - Regulation suppresses termination, halves timer rate.
// - Linear minimum-system mode caps current 2 A.
// - Linear disable: no minimum, phase current only.
// - Trickle exit 2.25V, hold 2.5V/cell briefly.
// - Fast threshold is ratio of regulation voltage.
// - Default charge voltage follows cell count.
// - Default fast current follows cell count.
// - Timer defaults 12 h, 2 h, trickle 1 h.
// - Input limit flags follow active limits.
// - Sagging minimum rail reduces charge current.
// - Rail below battery enters supplement mode.
// - Battery depletion exits supplement mode.
`timescale 1ns/1ps
`include "charge_seq_defs.svh"

module charge_cycle_sequencer #(
  parameter int unsigned DEGLITCH_CYC = `DEGLITCH_CYC,
  parameter int unsigned SHORTZ_CYC = `SHORTZ_CYC,
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
  parameter longint unsigned HOUR_CYC = `HOUR_CYC
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control bits written by the host
  input wire logic charge_enable_bit,
  input wire logic status_pin_disable,
  input wire logic linear_mode_disable,
  input wire logic [1:0] recharge_offset,
  input wire logic [1:0] cell_count,
  input wire logic use_defaults,
  input wire logic [15:0] battery_regulation_voltage,
  input wire logic [15:0] fast_charge_current,
  input wire logic [15:0] precharge_current,
  input wire logic [15:0] termination_current,
  input wire logic [7:0] fast_timer_setting,
  input wire logic precharge_timer_setting,
  // Pins and analog sense from other domains
  input wire logic charge_enable_n,
  input wire logic input_present,
  input wire logic [15:0] battery_mv,
  input wire logic [15:0] system_mv,
  input wire logic [15:0] min_system_voltage,
  input wire logic [15:0] depletion_mv,
  input wire logic [15:0] charge_ma,
  input wire logic input_voltage_limit_hit,
  input wire logic input_current_limit_hit,
  input wire logic thermal_reg,
  input wire logic ts_fault,
  // Status outputs
  output logic [2:0] charge_phase_code,
  output logic status_pin_out,
  output logic status_pin_oe,
  output logic alert_n,
  output logic input_voltage_limit_flag,
  output logic input_current_limit_flag,
  output logic min_system_active,
  output logic supplement_mode,
  output logic battery_switch_on,
  output logic timer_fault,
  // Regulation targets to the analog loops
  output logic [15:0] current_target_ma,
  output logic [15:0] voltage_target_mv
);
  import charge_seq_pkg::*;

  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] s1_r, s2_r;
  logic [15:0] vb1_r, vb_r, vs1_r, vs_r, ic1_r, ic_r;
  seq_state_t state_r, state_nxt;
  logic [31:0] dg_r, sz_r, blink_cnt_r;
  logic [63:0] tmr_r;
  logic half_r, blink_r, en_prev_r;
  logic [7:0] alert_cnt_r;
  logic [2:0] code_nxt;

  // Two-flop synchronisers; only the second stage is read.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      vb1_r <= 16'h0000;
      vb_r <= 16'h0000;
      vs1_r <= 16'h0000;
      vs_r <= 16'h0000;
      ic1_r <= 16'h0000;
      ic_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      s1_r <= {~charge_enable_n, input_present, input_voltage_limit_hit,
               input_current_limit_hit, thermal_reg, ts_fault, 3'h0};
      s2_r <= s1_r;
      vb1_r <= battery_mv;
      vb_r <= vb1_r;
      vs1_r <= system_mv;
      vs_r <= vs1_r;
      ic1_r <= charge_ma;
      ic_r <= ic1_r;
    end
  end

  logic pin_en, input_rail_ok, vin_lim, iin_lim, treg, tsf;
  assign pin_en = s2_r[8];
  assign input_rail_ok = s2_r[7];
  assign vin_lim = s2_r[6];
  assign iin_lim = s2_r[5];
  assign treg = s2_r[4];
  assign tsf = s2_r[3];

  logic enabled, regulating;
  assign enabled = charge_enable_bit & pin_en;
  assign regulating = vin_lim | iin_lim | treg;

  logic [15:0] battery_regulation_voltage_mv, fast_charge_current_ma, ipre_ma, termination_current_ma, rechg_mv, lowv_mv;
  logic [31:0] lowv_prod;
  assign battery_regulation_voltage_mv = use_defaults ? 16'(`BATTERY_REGULATION_VOLTAGE_STEP_MV * ({14'h0, cell_count} + 16'h0001))
                                : battery_regulation_voltage;
  assign fast_charge_current_ma = use_defaults ? (cell_count[1] ? `FAST_DEF_HI_MA : `FAST_DEF_LO_MA)
                                : fast_charge_current;
  assign ipre_ma = use_defaults ? `PRECHG_DEF_MA : precharge_current;
  assign termination_current_ma = use_defaults ? `TERM_DEF_MA : termination_current;
  assign rechg_mv = battery_regulation_voltage_mv - 16'(`RECHG_STEP_MV * ({14'h0, recharge_offset} + 16'h0001));
  assign lowv_prod = battery_regulation_voltage_mv * `LOWV_RATIO_NUM;
  assign lowv_mv = 16'(lowv_prod / `LOWV_RATIO_DEN);

  logic below_rechg, deglitched, timer_exp;
  assign below_rechg = vb_r < rechg_mv;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dg_r <= 32'h0;
    else if (clk_en)
    begin
      if (!below_rechg)
        dg_r <= 32'h0;
      else if (dg_r < DEGLITCH_CYC)
        dg_r <= dg_r + 32'h1;
    end
  end
  assign deglitched = (dg_r >= DEGLITCH_CYC);

  logic [63:0] limit_cyc;
  always_comb
  begin
    case (state_r)
      ST_TRICKLE, ST_SHORTZ: limit_cyc = HOUR_CYC * 64'(`TRICKLE_TMR_H);
      ST_PRE: limit_cyc = HOUR_CYC *
        (precharge_timer_setting ? 64'h1 : 64'(`PRE_TMR_DEF_H));
      default: limit_cyc = HOUR_CYC *
        (use_defaults ? 64'(`FAST_TMR_DEF_H) : 64'(fast_timer_setting));
    endcase
  end
  assign timer_exp = (tmr_r >= limit_cyc);

  logic en_rise;
  assign en_rise = enabled & ~en_prev_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_DONE:
        if (input_rail_ok && enabled && !tsf && (deglitched || en_rise))
          state_nxt = (vb_r < `SHORT_EXIT_MV) ? ST_TRICKLE :
                      (vb_r < lowv_mv) ? ST_PRE : ST_CC;
      ST_TRICKLE:
        if (vb_r >= `SHORT_EXIT_MV)
          state_nxt = ST_SHORTZ;
      ST_SHORTZ:
        if (sz_r >= SHORTZ_CYC)
          state_nxt = ST_PRE;
      ST_PRE:
        if (vb_r >= lowv_mv)
          state_nxt = ST_CC;
      ST_CC:
        if (vb_r >= battery_regulation_voltage_mv)
          state_nxt = ST_CV;
      ST_CV:
        if (ic_r < termination_current_ma && vb_r > rechg_mv && !regulating)
          state_nxt = ST_DONE;
      default:
        state_nxt = state_r;
    endcase
    if (state_r != ST_IDLE && state_r != ST_DONE && state_r != ST_FAULT && timer_exp)
      state_nxt = ST_FAULT;
    if (!enabled || !input_rail_ok || tsf)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_prev_r <= 1'b0;
    else if (clk_en)
      en_prev_r <= enabled;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sz_r <= 32'h0;
    else if (clk_en)
      sz_r <= (state_r == ST_SHORTZ) ? sz_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_r <= 64'h0;
      half_r <= 1'b0;
    end
    else if (clk_en)
    begin
      half_r <= ~half_r;
      if (state_nxt != state_r)
        tmr_r <= 64'h0;
      else if (!regulating || half_r)
        tmr_r <= tmr_r + 64'h1;
    end
  end

  always_comb
  begin
    case (state_r)
      ST_TRICKLE: code_nxt = `PH_TRICKLE;
      ST_SHORTZ, ST_PRE: code_nxt = `PH_PRE;
      ST_CC: code_nxt = `PH_CC;
      ST_CV: code_nxt = `PH_CV;
      ST_DONE: code_nxt = `PH_DONE;
      default: code_nxt = `PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      charge_phase_code <= `PH_IDLE;
      alert_cnt_r <= 8'h00;
      alert_n <= 1'b1;
    end
    else if (clk_en)
    begin
      charge_phase_code <= code_nxt;
      if (code_nxt != charge_phase_code)
        alert_cnt_r <= `ALERT_CYC;
      else if (alert_cnt_r != 8'h00)
        alert_cnt_r <= alert_cnt_r - 8'h01;
      alert_n <= !((code_nxt != charge_phase_code) || (alert_cnt_r > 8'h01));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (blink_cnt_r >= BLINK_HALF_CYC - 32'h1)
      begin
        blink_cnt_r <= 32'h0;
        blink_r <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_pin_out <= 1'b1;
      status_pin_oe <= 1'b0;
      timer_fault <= 1'b0;
    end
    else if (clk_en)
    begin
      timer_fault <= (state_r == ST_FAULT);
      status_pin_oe <= !status_pin_disable;
      if (state_r == ST_FAULT || tsf)
        status_pin_out <= blink_r;
      else
        status_pin_out <= (state_r == ST_IDLE || state_r == ST_DONE);
    end
  end

  logic charging, ldo, sag;
  logic [15:0] phase_ma, cur_ma;
  assign charging = !(state_r == ST_IDLE || state_r == ST_DONE || state_r == ST_FAULT);
  assign ldo = !linear_mode_disable && (vb_r < min_system_voltage);
  assign sag = ldo && (vs_r < min_system_voltage);
  always_comb
  begin
    case (state_r)
      ST_TRICKLE: phase_ma = `TRICKLE_MA;
      ST_SHORTZ, ST_PRE: phase_ma = ipre_ma;
      default: phase_ma = fast_charge_current_ma;
    endcase
    cur_ma = (ldo && state_r != ST_TRICKLE && phase_ma > `LDO_CAP_MA) ? `LDO_CAP_MA : phase_ma;
    if (sag)
      cur_ma = 16'h0000;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_target_ma <= 16'h0000;
      voltage_target_mv <= 16'h0000;
      min_system_active <= 1'b0;
      supplement_mode <= 1'b0;
      battery_switch_on <= 1'b0;
      input_voltage_limit_flag <= 1'b0;
      input_current_limit_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      current_target_ma <= charging ? cur_ma : 16'h0000;
      voltage_target_mv <= (state_r == ST_SHORTZ) ?
        16'(`SHORTZ_REG_MV_CELL * ({14'h0, cell_count} + 16'h0001)) : battery_regulation_voltage_mv;
      min_system_active <= ldo;
      input_voltage_limit_flag <= vin_lim;
      input_current_limit_flag <= iin_lim;
      if (vs_r < vb_r && vb_r >= depletion_mv)
        supplement_mode <= 1'b1;
      else if (vb_r < depletion_mv || vs_r >= vb_r + `IDEAL_DIODE_MV)
        supplement_mode <= 1'b0;
      battery_switch_on <= (charging || supplement_mode) && vb_r >= depletion_mv;
    end
  end
endmodule

// [dv/charge_seq_assertions.sv]
/*
  Port checker for the charge cycle sequencer.
  Assumes one clock domain and a bind to every sequencer instance.
*/
`timescale 1ns/1ps
`include "charge_seq_defs.svh"
module charge_seq_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched inputs
  input wire logic status_pin_disable,
  input wire logic use_defaults,
  input wire logic [1:0] cell_count,
  input wire logic input_voltage_limit_hit,
  input wire logic input_current_limit_hit,
  // Watched outputs
  input wire logic [2:0] charge_phase_code,
  input wire logic status_pin_out,
  input wire logic status_pin_oe,
  input wire logic alert_n,
  input wire logic input_voltage_limit_flag,
  input wire logic input_current_limit_flag,
  input wire logic min_system_active,
  input wire logic [15:0] current_target_ma
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cv_then_done;
    charge_phase_code == `PH_CV ##1 charge_phase_code == `PH_DONE;
  endsequence
  sequence s_steady_cc;
    (use_defaults && !min_system_active && charge_phase_code == `PH_CC) [*2];
  endsequence
  property p_alert_on_change;
    $changed(charge_phase_code) |-> !alert_n;
  endproperty
  a_alert_on_change: assert property (p_alert_on_change) else $error("no alert");
  property p_alert_hold;
    $fell(alert_n) |-> !alert_n [*8];
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert too short");
  property p_stat_release;
    status_pin_disable [*2] |-> !status_pin_oe;
  endproperty
  a_stat_release: assert property (p_stat_release) else $error("status driven");
  property p_stat_charging;
    (status_pin_oe && charge_phase_code inside {[`PH_TRICKLE:`PH_CV]}) [*3] |-> !status_pin_out;
  endproperty
  a_stat_charging: assert property (p_stat_charging) else $error("status high");
  property p_code_legal;
    charge_phase_code != 3'h5;
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("reserved code");
  property p_vflag;
    input_voltage_limit_hit [*4] |-> input_voltage_limit_flag;
  endproperty
  a_vflag: assert property (p_vflag) else $error("voltage flag low");
  property p_iflag;
    !input_current_limit_hit [*4] |-> !input_current_limit_flag;
  endproperty
  a_iflag: assert property (p_iflag) else $error("current flag high");
  property p_term_free;
    s_cv_then_done |-> !input_voltage_limit_flag && !input_current_limit_flag;
  endproperty
  a_term_free: assert property (p_term_free) else $error("ended in limit");
  property p_fast_default;
    s_steady_cc |-> current_target_ma == (cell_count < 2'h2 ? `FAST_DEF_LO_MA : `FAST_DEF_HI_MA);
  endproperty
  a_fast_default: assert property (p_fast_default) else $error("fast current");
endmodule
bind charge_cycle_sequencer charge_seq_checker chk_u (.ref_clk, .rst_n, .status_pin_disable,
  .use_defaults, .cell_count, .input_voltage_limit_hit, .input_current_limit_hit,
  .charge_phase_code, .status_pin_out, .status_pin_oe, .alert_n, .input_voltage_limit_flag,
  .input_current_limit_flag, .min_system_active, .current_target_ma);

// [dv/cell_model.sv]
/*
  Battery cell model driven by the sequencer's regulation targets.
  Assumes mV and mA units and a bench that preloads the cell voltage.
*/
`timescale 1ns/1ps
module cell_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic load,
  input wire logic [15:0] load_mv,
  input wire logic discharge,
  // Targets
  input wire logic [15:0] current_target_ma,
  input wire logic [15:0] voltage_target_mv,
  // Sensed cell
  output logic [15:0] battery_mv,
  output logic [15:0] charge_ma
);
  // Current tapers only once the voltage target is reached, so termination is honest.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      battery_mv <= 16'h1068;
      charge_ma <= 16'h0000;
    end
    else if (load)
      battery_mv <= load_mv;
    else if (current_target_ma == 16'h0000)
    begin
      charge_ma <= 16'h0000;
      if (discharge)
        battery_mv <= battery_mv - 16'h0004;
    end
    else if (battery_mv < voltage_target_mv)
    begin
      charge_ma <= current_target_ma;
      battery_mv <= (voltage_target_mv - battery_mv > 16'h0028) ? battery_mv + 16'h0028 :
        voltage_target_mv;
    end
    else
      charge_ma <= (charge_ma > 16'h0040) ? charge_ma - 16'h0040 : 16'h0000;
  end
endmodule

// [dv/charge_cycle_sequencer_tb.sv]
/*
  Self-checking bench for the charge cycle sequencer with a cell model.
  Assumes the design header is on the include path.
*/
`timescale 1ns/1ps
`include "charge_seq_defs.svh"
module charge_cycle_sequencer_tb;
  logic ref_clk, rst_n, clk_en, charge_enable_bit, status_pin_disable, linear_mode_disable;
  logic use_defaults, precharge_timer_setting, charge_enable_n, input_present, thermal_reg;
  logic input_voltage_limit_hit, input_current_limit_hit, ts_fault, load, discharge;
  logic [1:0] recharge_offset, cell_count;
  logic [7:0] fast_timer_setting;
  logic [15:0] battery_regulation_voltage, fast_charge_current, precharge_current, rnd;
  logic [15:0] termination_current, battery_mv, system_mv, min_system_voltage, depletion_mv;
  logic [15:0] charge_ma, current_target_ma, voltage_target_mv, load_mv;
  logic [2:0] charge_phase_code;
  logic status_pin_out, status_pin_oe, alert_n, input_voltage_limit_flag, timer_fault;
  logic input_current_limit_flag, min_system_active, supplement_mode, battery_switch_on;
  logic [2:0] seen[$];
  logic [2:0] exp_seq [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int w = 0;
  charge_cycle_sequencer #(.DEGLITCH_CYC(16), .SHORTZ_CYC(8), .BLINK_HALF_CYC(4),
    .HOUR_CYC(1024)) dut_u (.ref_clk, .rst_n, .clk_en, .charge_enable_bit, .status_pin_disable,
    .linear_mode_disable, .recharge_offset, .cell_count, .use_defaults,
    .battery_regulation_voltage, .fast_charge_current, .precharge_current, .termination_current,
    .fast_timer_setting, .precharge_timer_setting, .charge_enable_n, .input_present, .battery_mv,
    .system_mv, .min_system_voltage, .depletion_mv, .charge_ma, .input_voltage_limit_hit,
    .input_current_limit_hit, .thermal_reg, .ts_fault, .charge_phase_code, .status_pin_out,
    .status_pin_oe, .alert_n, .input_voltage_limit_flag, .input_current_limit_flag,
    .min_system_active, .supplement_mode, .battery_switch_on, .timer_fault, .current_target_ma,
    .voltage_target_mv);
  cell_model cell_u (.ref_clk, .rst_n, .load, .load_mv, .discharge, .current_target_ma,
    .voltage_target_mv, .battery_mv, .charge_ma);
  function automatic logic [15:0] exp_battery_regulation_voltage(input logic [1:0] c);
    exp_battery_regulation_voltage = `BATTERY_REGULATION_VOLTAGE_1S_MV * (16'(c) + 16'h0001);
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic wait_code(input logic [2:0] c, input bit eq);
    int k;
    k = 0;
    while (((charge_phase_code === c) != eq) && k < 8000)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 8000)
    begin
      n_fail++;
      $display("ERROR %0t phase code wait timed out", $time);
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    #1;
    if (seen.size() == 0 || seen[$] !== charge_phase_code)
      seen.push_back(charge_phase_code);
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    {rst_n, charge_enable_bit, status_pin_disable, linear_mode_disable, thermal_reg} = '0;
    {input_voltage_limit_hit, input_current_limit_hit, ts_fault, load, discharge} = '0;
    {clk_en, use_defaults, charge_enable_n, input_present} = 4'hf;
    {recharge_offset, cell_count, fast_timer_setting, precharge_timer_setting} = '0;
    {battery_regulation_voltage, fast_charge_current, precharge_current} = '0;
    {termination_current, load_mv, depletion_mv} = '0;
    system_mv = 16'h7530;
    min_system_voltage = 16'h03e8;
    rnd = 16'($urandom(70));
    repeat (10) @(posedge ref_clk);
    #1;
    cmp(16'({charge_phase_code, alert_n, status_pin_out, status_pin_oe}), 16'h0006, "reset");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      cell_count <= (i == 0) ? 2'h3 : 2'($urandom);
      recharge_offset <= 2'($urandom);
      {battery_regulation_voltage, fast_charge_current} <= {16'($urandom), 16'($urandom)};
      {precharge_current, termination_current} <= {16'($urandom), 16'($urandom)};
      {fast_timer_setting, precharge_timer_setting} <= 9'($urandom);
      {load_mv, load} <= {16'h03e8, 1'b1};
      @(posedge ref_clk);
      // The cell must read low before the first enable edge reaches the sequencer.
      load <= 1'b0;
      {charge_enable_bit, charge_enable_n} <= 2'b10;
      seen = {};
      wait_code(`PH_TRICKLE, 1);
      cmp(current_target_ma, `TRICKLE_MA, "trickle current");
      wait_code(`PH_CC, 1);
      cmp(current_target_ma, (cell_count < 2'h2) ? `FAST_DEF_LO_MA : `FAST_DEF_HI_MA, "fast");
      cmp(voltage_target_mv, exp_battery_regulation_voltage(cell_count), "charge voltage");
      wait_code(`PH_DONE, 1);
      cmp(16'({status_pin_out, charge_phase_code}), 16'h000f, "done state");
      for (int k = 0; k < 5; k++)
        cmp(16'(seen[seen.size() - 5 + k]), 16'(exp_seq[k]), "phase order");
      @(posedge ref_clk);
      discharge <= 1'b1;
      rnd = exp_battery_regulation_voltage(cell_count) - `RECHG_STEP_MV * (16'(recharge_offset) + 16'h0001);
      w = 0;
      while (battery_mv >= rnd && w < 8000)
      begin
        @(posedge ref_clk);
        #1;
        w++;
      end
      cmp(16'(battery_mv < rnd), 16'h0001, "recharge level");
      cmp(16'(charge_phase_code), 16'(`PH_DONE), "early recharge");
      wait_code(`PH_DONE, 0);
      cmp(16'(charge_phase_code), 16'(`PH_CC), "recharge phase");
      @(posedge ref_clk);
      discharge <= 1'b0;
      wait_code(`PH_DONE, 1);
    end
    for (int j = 0; j < 2; j++)
    begin
      @(posedge ref_clk);
      {charge_enable_bit, charge_enable_n} <= (j == 0) ? 2'b00 : 2'b11;
      wait_code(`PH_IDLE, 1);
      cmp(16'(status_pin_out), 16'h0001, "status disabled");
      @(posedge ref_clk);
      {charge_enable_bit, charge_enable_n} <= 2'b10;
      wait_code(`PH_IDLE, 0);
      cmp(16'(charge_phase_code != `PH_IDLE), 16'h0001, "restart");
      wait_code(`PH_DONE, 1);
    end
    // Limits and faults are held five cycles so the synchronisers settle.
    repeat (40)
    begin
      repeat (5) @(posedge ref_clk);
      {input_voltage_limit_hit, input_current_limit_hit, thermal_reg} <= 3'($urandom);
      {linear_mode_disable, ts_fault, status_pin_disable} <= 3'($urandom);
    end
    @(posedge ref_clk);
    {input_voltage_limit_hit, input_current_limit_hit, thermal_reg, ts_fault} <= 4'h0;
    {status_pin_disable, system_mv} <= {1'b1, battery_mv - 16'h0064};
    repeat (6) @(posedge ref_clk);
    #1;
    cmp(16'(status_pin_oe), 16'h0000, "status released");
    cmp(16'({supplement_mode, battery_switch_on}), 16'h0003, "supplement");
    @(posedge ref_clk);
    depletion_mv <= battery_mv + 16'h0064;
    repeat (6) @(posedge ref_clk);
    #1;
    cmp(16'({supplement_mode, battery_switch_on}), 16'h0000, "depleted");
    give_verdict();
  end
endmodule
